// File: hdl/cvq_core.sv
/*
 * Core voltage identification qualifier: drives the five voltage code lines
 * and two bus speed lines open-drain, then raises the power-good qualifier
 * once they have stood stable for 24 clocks, one short of the 25-clock settle time.
 * Assumes one 25 MHz clock, a synchronous active-low reset and board pull-ups.
 */
`timescale 1ns/1ns
`default_nettype none
module cvq_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Request from the core
	input wire logic code_valid,
	input wire logic [4:0] level_step,
	input wire logic [1:0] bus_speed_select,
	input wire logic half_step_tied,
	// Code and bus speed pins
	input wire logic [6:0] code_line_i,
	output logic [6:0] code_line_o,
	output logic [6:0] code_line_oe,
	// Qualifier pin
	output logic termination_power_good,
	// Status to the core
	output logic code_locked,
	output logic line_fault
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cvq_pkg::cvq_state_t state_r;
	cvq_pkg::cvq_state_t state_nxt;
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic [6:0] code_r;
	logic [6:0] code_nxt;
	logic good_r;
	logic good_nxt;
	logic locked_r;
	logic fault_r;
	logic fault_nxt;
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;

	cvq_line_if lines ();

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	wire logic [4:0] vid_code;
	wire logic [6:0] req_code;
	wire logic settle_done;
	wire logic in_release;
	wire logic in_settle;
	wire logic in_good;
	wire logic line_mismatch;

	assign vid_code = cvq_pkg::cvq_encode(level_step, half_step_tied);
	assign req_code = {bus_speed_select, vid_code};
	assign settle_done = (cnt_r == cvq_pkg::CVQ_CNT_LAST);
	assign in_release = (state_r == cvq_pkg::CVQ_ST_RELEASE);
	assign in_settle = (state_r == cvq_pkg::CVQ_ST_SETTLE);
	assign in_good = (state_r == cvq_pkg::CVQ_ST_GOOD);
	assign line_mismatch = good_r & (sync2_r != code_r);

	assign lines.level = code_r;
	assign lines.drive = ~in_release;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		code_nxt = code_r;
		good_nxt = good_r;
		case (state_r)
			cvq_pkg::CVQ_ST_RELEASE: begin
				good_nxt = 1'b0;
				cnt_nxt = cvq_pkg::CVQ_CNT_ZERO;
				if (code_valid) begin
					code_nxt = req_code;
					state_nxt = cvq_pkg::CVQ_ST_SETTLE;
				end
			end
			cvq_pkg::CVQ_ST_SETTLE: begin
				if (!code_valid) begin
					state_nxt = cvq_pkg::CVQ_ST_RELEASE;
				end else if (settle_done) begin
					good_nxt = 1'b1;
					state_nxt = cvq_pkg::CVQ_ST_GOOD;
				end else begin
					cnt_nxt = cnt_r + cvq_pkg::CVQ_CNT_ONE;
				end
			end
			cvq_pkg::CVQ_ST_GOOD: begin
				if (!code_valid) begin
					good_nxt = 1'b0;
					state_nxt = cvq_pkg::CVQ_ST_RELEASE;
				end
			end
			default: begin
				good_nxt = 1'b0;
				state_nxt = cvq_pkg::CVQ_ST_RELEASE;
			end
		endcase
	end

	assign fault_nxt = fault_r | line_mismatch;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= cvq_pkg::CVQ_ST_RELEASE;
			cnt_r <= cvq_pkg::CVQ_CNT_ZERO;
			code_r <= cvq_pkg::CVQ_LINES_RELEASED;
			good_r <= 1'b0;
			locked_r <= 1'b0;
			fault_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			code_r <= code_nxt;
			good_r <= good_nxt;
			locked_r <= ~(state_nxt == cvq_pkg::CVQ_ST_RELEASE);
			fault_r <= fault_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Pin readback synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_r <= cvq_pkg::CVQ_LINES_RST;
			sync2_r <= cvq_pkg::CVQ_LINES_RST;
		end else begin
			sync1_r <= code_line_i;
			sync2_r <= sync1_r;
		end
	end

	// ----------------------------------------------------------------
	// Pin stage
	// ----------------------------------------------------------------
	cvq_od_drive u_drive (
		.clk(clk),
		.rst_n(rst_n),
		.lines(lines),
		.line_o(code_line_o),
		.line_oe(code_line_oe)
	);

	assign termination_power_good = good_r;
	assign code_locked = locked_r;
	assign line_fault = fault_r;

	wire logic unused_states;
	assign unused_states = in_settle | in_good;

endmodule : cvq_core
`default_nettype wire

// File: hdl/cvq_line_if.sv
/*
 * Carries the requested line levels from the sequencer to the open-drain
 * pin stage.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface cvq_line_if;
	logic [6:0] level;
	logic drive;

	modport src (output level, output drive);
	modport drv (input level, input drive);
endinterface : cvq_line_if
`default_nettype wire

// File: hdl/cvq_od_drive.sv
/*
 * Open-drain pin stage: a line pulls low only where its level is zero.
 * Assumes the board pull-up lifts every released line.
 */
`timescale 1ns/1ns
`default_nettype none
module cvq_od_drive (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Requested levels
	cvq_line_if.drv lines,
	// Pins
	output logic [6:0] line_o,
	output logic [6:0] line_oe
);
	// ----------------------------------------------------------------
	// Per-line drivers
	// ----------------------------------------------------------------
	wire logic [6:0] pull_low;

	genvar gi;
	generate
		for (gi = 0; gi < cvq_pkg::CVQ_LINE_W; gi++) begin : g_line
			assign pull_low[gi] = lines.drive & ~lines.level[gi];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			line_oe <= cvq_pkg::CVQ_LINES_RST;
			line_o <= cvq_pkg::CVQ_LINES_RST;
		end else begin
			line_oe <= pull_low;
			line_o <= cvq_pkg::CVQ_LINES_RST;
		end
	end

endmodule : cvq_od_drive
`default_nettype wire

// File: hdl/cvq_pkg.sv
/*
 * Constants, line layout and the step encoding for the core voltage
 * identification qualifier.
 * Assumes a single 25 MHz clock domain and no software-visible registers.
 */
package cvq_pkg;

	// ----------------------------------------------------------------
	// Line layout
	// ----------------------------------------------------------------
	localparam int CVQ_MAIN_W = 4;
	localparam int CVQ_BSEL_W = 2;
	localparam int CVQ_STEP_W = 5;
	localparam int CVQ_LINE_W = 7;
	localparam int CVQ_HALF_BIT = 4;
	localparam int CVQ_BSEL_LSB = 5;
	localparam int CVQ_BSEL_MSB = 6;

	// ----------------------------------------------------------------
	// Encoding and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] CVQ_MAIN_BASE = 4'h4;
	localparam logic [6:0] CVQ_LINES_RELEASED = 7'h7f;
	localparam logic [6:0] CVQ_LINES_RST = 7'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CVQ_CLK_NS = 40;
	localparam int CVQ_SETTLE_NS = 1000;
	localparam int CVQ_SETTLE_CYC = (CVQ_SETTLE_NS + CVQ_CLK_NS - 1) / CVQ_CLK_NS;
	localparam int CVQ_CNT_W = 6;
	localparam logic [5:0] CVQ_CNT_ZERO = 6'h00;
	localparam logic [5:0] CVQ_CNT_ONE = 6'h01;
	localparam logic [5:0] CVQ_CNT_LAST = CVQ_CNT_W'(CVQ_SETTLE_CYC - 1);

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CVQ_ST_RELEASE = 3'h1,
		CVQ_ST_SETTLE = 3'h2,
		CVQ_ST_GOOD = 3'h4
	} cvq_state_t;

	// Maps a step count above 1.05 V in 25 mV units onto the line code.
	function automatic logic [4:0] cvq_encode(input logic [4:0] step, input logic half_tied);
		logic [3:0] main;
		logic half;
		main = CVQ_MAIN_BASE - step[4:1];
		half = step[0] & ~half_tied;
		return {half, main};
	endfunction : cvq_encode

endpackage : cvq_pkg

// File: test/core_voltage_id_qualifier_tb_top.sv
/* Testbench of cvq_core with a regulator model.
   Assumes pull-ups on all lines. */
`timescale 1ns/1ns
`default_nettype none
module core_voltage_id_qualifier_tb_top;
	logic clk, rst_n, code_valid, half_step_tied, pg, locked, fault, on, on_d;
	logic [4:0] level_step;
	logic [1:0] bus_speed_select;
	logic [6:0] pin, oe, bad;
	logic [10:0] mv;
	logic [15:0] q[$];
	int fail_count, compares, seed, n;
	assign pin = ~oe ^ bad;
	cvq_core u_cvq_core (.clk, .rst_n, .code_valid, .level_step, .bus_speed_select, .half_step_tied,
		.code_line_i(pin), .code_line_o(), .code_line_oe(oe), .termination_power_good(pg),
		.code_locked(locked), .line_fault(fault));
	cvq_vrm_model u_cvq_vrm_model (.clk, .pin, .power_good(pg), .on_r(on), .mv_r(mv));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task check(input logic [17:0] seen, input logic [17:0] want);
		compares++;
		if (seen !== want) begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task finish_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test
	task run(input logic [4:0] s, input logic [1:0] b, input logic t, input logic [6:0] c);
		code_valid = 1'b1;
		level_step = s;
		bus_speed_select = b;
		half_step_tied = t;
		q.push_back({11'h41a + 11'h019 * (t ? {s[4:1], 1'b0} : s), s[0] & ~t, 4'h4 - s[4:1]});
		n = 0;
		while (pg !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
			{level_step, bus_speed_select, half_step_tied} = 8'($random(seed));
		end
		check(18'(n inside {26, 27}), 18'h1);
		bad = c;
		repeat (5) @(negedge clk);
		check(18'(fault), 18'(|c));
		code_valid = 1'b0;
		@(negedge clk);
	endtask : run
	always @(negedge clk) begin
		if (on === 1'b1 && on_d !== 1'b1) check({mv, pin[4:0]}, q.pop_front());
		on_d = on;
	end
	initial begin
		seed = 32'h796ae991;
		bad = 7'h00;
		code_valid = 1'b0;
		level_step = 5'h00;
		bus_speed_select = 2'h0;
		half_step_tied = 1'b0;
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		check(18'(pin), 18'h7f);
		for (int i = 0; i < 64; i++) run(5'(i), 2'($random(seed)), i[5], 7'h00);
		run(5'h1f, 2'h1, 1'b0, 7'h20);
		repeat (4) @(negedge clk);
		check(18'(q.size()), 18'h0);
		finish_test();
	end
	initial begin
		#(40 * 5000);
		fail_count++;
		finish_test();
	end
endmodule : core_voltage_id_qualifier_tb_top
`default_nettype wire

// File: test/cvq_core_assertions.sv
/* Checker of the code and qualifier pins.
   Assumes binding to cvq_core. */
`timescale 1ns/1ns
`default_nettype none
module cvq_core_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Inputs
	input wire logic code_valid,
	input wire logic [4:0] level_step,
	input wire logic [1:0] bus_speed_select,
	input wire logic half_step_tied,
	input wire logic [6:0] code_line_i,
	// Outputs
	input wire logic [6:0] code_line_o,
	input wire logic [6:0] code_line_oe,
	input wire logic termination_power_good,
	input wire logic code_locked,
	input wire logic line_fault
);
	logic [6:0] want_w;
	assign want_w = ~{bus_speed_select, level_step[0] & ~half_step_tied, 4'h4 - level_step[4:1]};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence take_s;
		!code_locked ##1 code_locked;
	endsequence
	chk_line_low: assert property (code_line_o == 7'h00) else $error("line driven high");
	chk_take_code: assert property (take_s |=> code_line_oe == $past(want_w, 2)) else $error("bad code");
	chk_code_hold: assert property (code_locked[*4] |-> $stable(code_line_oe)) else $error("code moved");
	chk_pg_locked: assert property (termination_power_good |-> code_locked) else $error("early good");
	chk_pg_drop: assert property (!code_valid && termination_power_good |=> !termination_power_good)
		else $error("good kept");
	chk_settle_time: assert property ($rose(termination_power_good) |-> $past(code_locked, 24))
		else $error("short settle");
	chk_pg_quiet: assert property (take_s |-> !termination_power_good[*8]) else $error("good too soon");
	chk_release_all: assert property ($fell(code_locked) |=> code_line_oe == 7'h00) else $error("not released");
	chk_fault_sticky: assert property (line_fault |=> line_fault) else $error("fault lost");
endmodule : cvq_core_assertions
bind cvq_core cvq_core_assertions u_chk (.clk, .rst_n, .code_valid, .level_step, .bus_speed_select,
	.half_step_tied, .code_line_i, .code_line_o, .code_line_oe, .termination_power_good, .code_locked, .line_fault);
`default_nettype wire

// File: test/cvq_vrm_model.sv
/* Regulator model on the code lines.
   Assumes pull-up resolved pins. */
`timescale 1ns/1ns
`default_nettype none
module cvq_vrm_model #(parameter bit HALF_GND = 1'b0) (
	// Clock
	input wire logic clk,
	// Lines
	input wire logic [6:0] pin,
	input wire logic power_good,
	// Output
	output var logic on_r,
	output var logic [10:0] mv_r
);
	logic seen_r = 1'b0;
	logic [3:0] idx_w;
	assign idx_w = 4'h4 - pin[3:0];
	initial on_r = 1'b0;
	always @(posedge clk) begin
		seen_r <= power_good;
		on_r <= seen_r & power_good;
		if (seen_r & power_good & ~on_r) begin
			mv_r <= 11'h41a + 11'h032 * idx_w + ((pin[4] & ~HALF_GND) ? 11'h019 : 11'h000);
		end
	end
endmodule : cvq_vrm_model
`default_nettype wire
